// file: design/bipm_chan.sv
// Per-channel polarity and simulation stage, one flop per channel.
// Assumes raw inputs are already synchronous to clock.
`timescale 1ns/1ps
module bipm_chan (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  bipm_chan_if.chan bus
);
  logic [15:0] state_reg;
  logic [15:0] state_next;

  // --------------------------------------------------------------
  // Channel mode application
  // --------------------------------------------------------------
  for (genvar i = 0; i < bipm_pkg::NCH; i++) begin : g_ch
    // [R02] Own mode only
    always_comb begin
      // [R01] Mode decode
      unique case (bus.mode[2*i +: 2])
        bipm_pkg::MODE_POS:  state_next[i] = bus.raw[i];
        bipm_pkg::MODE_NEG:  state_next[i] = ~bus.raw[i];
        bipm_pkg::MODE_SIM0: state_next[i] = 1'b0;
        bipm_pkg::MODE_SIM1: state_next[i] = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= 16'h0000;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign bus.state = state_reg;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  chk_pass_mode: assert property (@(posedge clock) disable iff (!rstn) // [R01]
    ce && bus.mode[1:0] == bipm_pkg::MODE_POS |=> state_reg[0] == $past(bus.raw[0]))
    else $error("channel 1 did not pass its input");
  chk_force_one: assert property (@(posedge clock) disable iff (!rstn) // [R01]
    ce && bus.mode[31:30] == bipm_pkg::MODE_SIM1 |=> state_reg[15])
    else $error("channel 16 not forced high");
endmodule

// file: design/bipm_top.sv
// Sixteen-channel binary input card: operating matrix, lock, reset command,
// label, error history and alarm outputs.
// Assumes both access ports are synchronous to clock and hold a request
// for one cycle; the terminal port shuts out the gateway while plugged in.
`timescale 1ns/1ps
module bipm_top #(
  parameter logic [15:0] FW_NUMBER = bipm_pkg::FW_DEFAULT // Value arbitrary
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [15:0] chan_in,
  input  wire logic [5:0]  addr_sw,
  input  wire logic [5:0]  hw_fault,
  input  wire logic        battery_low,
  input  wire logic        term_present,
  input  wire logic        term_req,
  input  wire logic        term_we,
  input  wire logic [3:0]  term_row,
  input  wire logic [3:0]  term_col,
  input  wire logic [15:0] term_wdata,
  input  wire logic        gw_req,
  input  wire logic        gw_we,
  input  wire logic [3:0]  gw_row,
  input  wire logic [3:0]  gw_col,
  input  wire logic [15:0] gw_wdata,
  output logic             rsp_ack,
  output logic [15:0]      rsp_data,
  output logic             rsp_refused,
  output logic             rsp_from_term,
  output logic             relay_energised,
  output logic             alarm_led
);
  bipm_chan_if cbus ();

  // --------------------------------------------------------------
  // Request selection
  // --------------------------------------------------------------
  logic        req;
  logic        we;
  logic [3:0]  row;
  logic [3:0]  col;
  logic [15:0] wdata;

  always_comb begin
    // [R18] Terminal shuts out gateway
    if (term_present) begin
      req   = term_req;
      we    = term_we;
      row   = term_row;
      col   = term_col;
      wdata = term_wdata;
    end else begin
      req   = gw_req;
      we    = gw_we;
      row   = gw_row;
      col   = gw_col;
      wdata = gw_wdata;
    end
  end

  // --------------------------------------------------------------
  // Parameter state
  // --------------------------------------------------------------
  logic [31:0] mode_reg;
  logic [31:0] mode_next;
  logic [15:0] lock_reg;
  logic [15:0] lock_next;
  logic [63:0] label_reg;
  logic [63:0] label_next;
  logic [5:0]  addr_reg;
  logic        locked;
  logic        hit_mode;
  logic [3:0]  mode_ch;
  logic        hit_lock;
  logic        hit_reset;
  logic        hit_label;
  logic [31:0] wr_mask;

  // [R05] Outside the key window means locked
  assign locked    = !bipm_pkg::in_key(lock_reg);
  // [R03] Mode columns 0-7 of rows 1 and 3
  assign hit_mode  = (row == bipm_pkg::ROW_MODE_LO || row == bipm_pkg::ROW_MODE_HI) && !col[3];
  assign mode_ch   = {row == bipm_pkg::ROW_MODE_HI, col[2:0]};
  assign hit_lock  = row == bipm_pkg::ROW_LOCK && col == bipm_pkg::COL_LOCK;
  assign hit_reset = row == bipm_pkg::ROW_DIAG && col == bipm_pkg::COL_RESET;
  assign hit_label = row == bipm_pkg::ROW_LABEL && col == bipm_pkg::COL_LABEL;
  assign wr_mask   = 32'h0000_0003 << {mode_ch, 1'b0};

  always_comb begin
    mode_next  = mode_reg;
    lock_next  = lock_reg;
    label_next = label_reg;
    if (req && we) begin
      // [R19] Protected writes need an open lock
      if (hit_mode && !locked) begin
        // [R02] Only this channel's field
        mode_next = (mode_reg & ~wr_mask) | ({30'h0, wdata[1:0]} << {mode_ch, 1'b0});
      end
      // [R06] Lock position always writable
      if (hit_lock) begin
        lock_next = wdata;
      end
      // [R07] Keyed reset command
      if (hit_reset && bipm_pkg::in_key(wdata)) begin
        // [R08] Modes back to default
        mode_next = bipm_pkg::MODE_RESET;
      end
      // [R04] Label shifts in one word per write
      if (hit_label && !locked) begin
        label_next = {label_reg[47:0], wdata};
      end
    end else if (req && hit_label) begin
      // Reads rotate so four reads return the label in write order
      label_next = {label_reg[47:0], label_reg[63:48]};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_reg  <= bipm_pkg::MODE_RESET;
      lock_reg  <= bipm_pkg::LOCK_RESET;
      label_reg <= bipm_pkg::LABEL_RESET;
      addr_reg  <= bipm_pkg::ADDR_RESET;
    end else if (ce) begin
      mode_reg  <= mode_next;
      lock_reg  <= lock_next;
      label_reg <= label_next;
      // [R17] Switch weights equal binary place values
      addr_reg  <= addr_sw;
    end
  end

  assign cbus.mode = mode_reg;
  assign cbus.raw  = chan_in;

  bipm_chan u_chan (
    .clock (clock),
    .rstn  (rstn),
    .ce    (ce),
    .bus   (cbus)
  );

  // --------------------------------------------------------------
  // Fault history and alarm
  // --------------------------------------------------------------
  logic [6:0] fault_vec;
  logic [6:0] fault_prev_reg;
  logic [6:0] fault_rise;
  logic [7:0] err_cur_reg;
  logic [7:0] err_cur_next;
  logic [7:0] err_prev_reg;
  logic [7:0] err_prev_next;
  logic       relay_next;
  logic       led_next;

  assign fault_vec  = {battery_low, hw_fault};
  assign fault_rise = fault_vec & ~fault_prev_reg;

  always_comb begin
    err_cur_next  = err_cur_reg;
    err_prev_next = err_prev_reg;
    // [R15] New code pushes the old one down
    if (|fault_rise) begin
      // [R16] Code from fault source
      err_cur_next  = bipm_pkg::err_code(fault_rise);
      err_prev_next = err_cur_reg;
    end
    // [R13] Relay drops, red lamp on
    relay_next = ~|fault_vec;
    led_next   = |fault_vec;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fault_prev_reg  <= 7'h00;
      err_cur_reg     <= bipm_pkg::ERR_NONE;
      err_prev_reg    <= bipm_pkg::ERR_NONE;
      relay_energised <= 1'b0;
      alarm_led       <= 1'b0;
    end else if (ce) begin
      fault_prev_reg  <= fault_vec;
      err_cur_reg     <= err_cur_next;
      err_prev_reg    <= err_prev_next;
      relay_energised <= relay_next;
      alarm_led       <= led_next;
    end
  end

  // --------------------------------------------------------------
  // Read answer
  // --------------------------------------------------------------
  logic [15:0] rd_data;
  logic        bad;
  logic [15:0] st;

  assign st = cbus.state;

  always_comb begin
    rd_data = 16'h0000;
    bad     = 1'b0;
    unique case (row)
      // [R09] One channel per position
      bipm_pkg::ROW_STATE_LO: begin
        if (!col[3]) begin
          rd_data = {15'h0, st[col[2:0]]};
        // [R10] Packed low group
        end else if (col == bipm_pkg::COL_PACK_LO) begin
          rd_data = {8'h00, bipm_pkg::pack8(st[7:0])};
        // [R11] Packed high group
        end else if (col == bipm_pkg::COL_PACK_HI) begin
          rd_data = {8'h00, bipm_pkg::pack8(st[15:8])};
        end else begin
          bad = 1'b1;
        end
        bad = bad | we;
      end
      bipm_pkg::ROW_STATE_HI: begin
        rd_data = {15'h0, st[{1'b1, col[2:0]}]};
        bad     = col[3] | we;
      end
      bipm_pkg::ROW_MODE_LO, bipm_pkg::ROW_MODE_HI: begin
        rd_data = {14'h0, mode_reg[{mode_ch, 1'b0} +: 2]};
        bad     = col[3] | (we & locked);
      end
      bipm_pkg::ROW_LOCK: begin
        rd_data = lock_reg;
        bad     = !hit_lock;
      end
      bipm_pkg::ROW_DIAG: begin
        // [R14] [R20] Diagnostics row
        if (col == bipm_pkg::COL_ERR_CUR) begin
          rd_data = {8'h00, err_cur_reg};
        end else if (col == bipm_pkg::COL_ERR_PREV) begin
          rd_data = {8'h00, err_prev_reg};
        end else if (col == bipm_pkg::COL_FW) begin
          rd_data = FW_NUMBER;
        end else if (col == bipm_pkg::COL_ADDR) begin
          rd_data = {10'h000, addr_reg};
        end else if (!hit_reset) begin
          bad = 1'b1;
        end
        bad = bad | (we ^ hit_reset);
      end
      bipm_pkg::ROW_LABEL: begin
        rd_data = label_reg[63:48];
        bad     = !hit_label | (we & locked);
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rsp_ack       <= 1'b0;
      rsp_data      <= 16'h0000;
      rsp_refused   <= 1'b0;
      rsp_from_term <= 1'b0;
    end else if (ce) begin
      rsp_ack       <= req;
      rsp_data      <= (req && !we && !bad) ? rd_data : 16'h0000;
      rsp_refused   <= req & bad;
      rsp_from_term <= req & term_present;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  chk_chan_isolated: assert property (@(posedge clock) disable iff (!rstn) // [R02]
    ce && req && we && hit_mode && !hit_reset |=> (mode_reg & ~$past(wr_mask)) == $past(mode_reg & ~wr_mask))
    else $error("mode write disturbed another channel");
  chk_lock_release: assert property (@(posedge clock) disable iff (!rstn) // [R06]
    ce && req && we && hit_lock && bipm_pkg::in_key(wdata) |=> !locked)
    else $error("key did not release lock");
  chk_lock_set: assert property (@(posedge clock) disable iff (!rstn) // [R05]
    ce && req && we && hit_lock && wdata > bipm_pkg::KEY_HI |=> locked)
    else $error("high value did not lock");
  chk_reset_clears: assert property (@(posedge clock) disable iff (!rstn) // [R08]
    ce && req && we && hit_reset && bipm_pkg::in_key(wdata) |=> mode_reg == bipm_pkg::MODE_RESET)
    else $error("reset command left modes set");
  chk_locked_ignore: assert property (@(posedge clock) disable iff (!rstn) // [R19]
    ce && locked && req && we && (hit_mode || hit_label) && !hit_reset |=> $stable(mode_reg) && $stable(label_reg))
    else $error("write accepted while locked");
  chk_packed_order: assert property (@(posedge clock) disable iff (!rstn) // [R10]
    ce && req && !we && row == bipm_pkg::ROW_STATE_LO && col == bipm_pkg::COL_PACK_LO
    |=> rsp_ack && rsp_data[7] == $past(st[0]) && rsp_data[0] == $past(st[7]))
    else $error("packed bit order wrong");
  chk_alarm_relay: assert property (@(posedge clock) disable iff (!rstn) // [R13]
    ce && |fault_vec |=> !relay_energised && alarm_led)
    else $error("fault did not raise alarm");
  chk_error_shift: assert property (@(posedge clock) disable iff (!rstn) // [R15]
    ce && |fault_rise |=> err_prev_reg == $past(err_cur_reg) && err_cur_reg != bipm_pkg::ERR_NONE)
    else $error("error history not shifted");
  chk_term_blocks: assert property (@(posedge clock) disable iff (!rstn) // [R18]
    ce && term_present && !term_req |=> !rsp_ack)
    else $error("gateway served while terminal present");

  cov_lock_release: cover property (@(posedge clock) disable iff (!rstn) locked ##1 !locked);
  cov_reset_cmd:    cover property (@(posedge clock) disable iff (!rstn)
    req && we && hit_reset && bipm_pkg::in_key(wdata));
  cov_fault:        cover property (@(posedge clock) disable iff (!rstn) |fault_rise ##1 |fault_rise);
  cov_packed_read:  cover property (@(posedge clock) disable iff (!rstn)
    req && !we && row == bipm_pkg::ROW_STATE_LO && col == bipm_pkg::COL_PACK_HI);
endmodule

// file: pkg/bipm_chan_if.sv
// Carrier between the matrix core and the channel processor.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface bipm_chan_if;
  logic [31:0] mode;
  logic [15:0] raw;
  logic [15:0] state;
  modport core (output mode, output raw, input state);
  modport chan (input mode, input raw, output state);
endinterface

// file: pkg/bipm_pkg.sv
// Constants, codes and shared decode functions for the binary input matrix.
// Assumes a single 25 MHz clock domain; no timing counts are needed.
//
// Behaviour
// [R01] Each channel has a 2-bit mode: pass, invert, force 0, force 1.
// [R02] Every channel keeps its own mode and it affects only that channel.
// [R03] Modes for channels 1-8 at row 1 cols 0-7, 9-16 at row 3.
// [R04] Label written at row 10 col 1 is stored and read back.
// [R05] Writing a value outside 670..679 to row 8 col 9 locks the matrix.
// [R06] Writing 670..679 to the lock position releases the lock.
// [R07] Writing 670..679 to row 9 col 5 triggers the reset command.
// [R08] The reset command returns every channel mode to its default.
// [R09] Channel states readable at row 0 (ch 1-8) and row 2 (ch 9-16).
// [R10] Row 0 col 8 returns channels 1-8 packed, channel 1 in MSB.
// [R11] Row 0 col 9 returns channels 9-16 packed, channel 9 in MSB.
// [R12] Gateway lists address and position before polling by list entry; the code keeps no list, the gateway gives row and col on each access.
// [R13] A fault drops the alarm relay and lights the red indicator.
// [R14] Current error code is readable at row 9 col 0.
// [R15] Row 9 col 1 holds the code that was current before the latest.
// [R16] Codes 101-106 mean hardware faults, 107 means low battery.
// [R17] Station address is the weighted sum of six switches 1..32.
// [R18] While the terminal is plugged in, gateway access is disabled.
// [R19] When locked, mode and label writes are ignored; lock stays writable.
// [R20] Firmware number and station address read-only in diagnostics row.
package bipm_pkg;
  localparam int          NCH        = 16;
  localparam int          NGRP       = 8;
  localparam int          DW         = 16;
  localparam int          NHW        = 6;
  localparam int          LABEL_W    = 64;
  localparam logic [1:0]  MODE_POS   = 2'h0;
  localparam logic [1:0]  MODE_NEG   = 2'h1;
  localparam logic [1:0]  MODE_SIM0  = 2'h2;
  localparam logic [1:0]  MODE_SIM1  = 2'h3;
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [3:0]  ROW_STATE_LO = 4'h0;
  localparam logic [3:0]  ROW_MODE_LO  = 4'h1;
  localparam logic [3:0]  ROW_STATE_HI = 4'h2;
  localparam logic [3:0]  ROW_MODE_HI  = 4'h3;
  localparam logic [3:0]  ROW_LOCK     = 4'h8;
  localparam logic [3:0]  ROW_DIAG     = 4'h9;
  localparam logic [3:0]  ROW_LABEL    = 4'ha;
  localparam logic [3:0]  COL_PACK_LO  = 4'h8;
  localparam logic [3:0]  COL_PACK_HI  = 4'h9;
  localparam logic [3:0]  COL_LOCK     = 4'h9;
  localparam logic [3:0]  COL_ERR_CUR  = 4'h0;
  localparam logic [3:0]  COL_ERR_PREV = 4'h1;
  localparam logic [3:0]  COL_FW       = 4'h3;
  localparam logic [3:0]  COL_ADDR     = 4'h4;
  localparam logic [3:0]  COL_RESET    = 4'h5;
  localparam logic [3:0]  COL_LABEL    = 4'h1;
  localparam logic [15:0] KEY_LO       = 16'h029e;
  localparam logic [15:0] KEY_HI       = 16'h02a7;
  localparam logic [15:0] LOCK_RESET   = 16'h029e;
  localparam logic [7:0]  ERR_NONE     = 8'h00;
  localparam logic [7:0]  ERR_HW_BASE  = 8'h65;
  localparam logic [7:0]  ERR_BATTERY  = 8'h6b;
  localparam logic [15:0] FW_DEFAULT   = 16'h0100;
  localparam logic [63:0] LABEL_RESET  = 64'h0;
  localparam logic [5:0]  ADDR_RESET   = 6'h00;

  // Key window shared by lock release and reset command
  function automatic logic in_key(input logic [15:0] v);
    return (v >= KEY_LO) && (v <= KEY_HI);
  endfunction

  // First group channel lands in the MSB
  function automatic logic [7:0] pack8(input logic [7:0] s);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < NGRP; i++) begin
      r[NGRP-1-i] = s[i];
    end
    return r;
  endfunction

  // Lowest-numbered rising fault wins; index 6 is the battery
  function automatic logic [7:0] err_code(input logic [6:0] rise);
    logic [7:0] c;
    c = ERR_NONE;
    for (int i = NHW; i >= 0; i--) begin
      if (rise[i]) begin
        c = (i == NHW) ? ERR_BATTERY : ERR_HW_BASE + 8'(i);
      end
    end
    return c;
  endfunction
endpackage

// file: tb/bipm_host_model.sv
// Access-port master standing in for the gateway or the handheld terminal.
// Assumes the port under it takes a request at each rising edge it is high.
`timescale 1ns/1ps
module bipm_host_model (
  input  wire logic        clock,
  output logic             req,
  output logic             we,
  output logic [3:0]       row,
  output logic [3:0]       col,
  output logic [15:0]      wdata
);
  initial begin
    req   = 1'b0;
    we    = 1'b0;
    row   = 4'hf;
    col   = 4'hf;
    wdata = 16'h0;
  end

  task automatic access(input logic w, input logic [3:0] r, input logic [3:0] c, input logic [15:0] d);
    @(posedge clock);
    req   <= 1'b1;
    we    <= w;
    row   <= r;
    col   <= c;
    wdata <= d;
  endtask

  // Idle lines flip so a stale position is never trusted
  task automatic idle();
    @(posedge clock);
    req   <= 1'b0;
    we    <= ~we;
    row   <= ~row;
    col   <= ~col;
    wdata <= ~wdata;
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the binary input matrix.
// Assumes one ack per taken request, one cycle later.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  localparam logic [15:0] FW = 16'h0123; // Value arbitrary
  typedef struct {logic [15:0] data; logic refused; logic term;} bipm_exp_s;
  logic        clock, rstn, ce, battery_low, term_present;
  logic [15:0] chan_in;
  logic [5:0]  addr_sw, hw_fault;
  logic        t_req, t_we, g_req, g_we;
  logic [3:0]  t_row, t_col, g_row, g_col;
  logic [15:0] t_wdata, g_wdata, rsp_data;
  logic        rsp_ack, rsp_refused, rsp_from_term, relay_energised, alarm_led;
  int          n_tests = 0;
  int          n_mismatch = 0;
  bipm_exp_s   expq[$];

  always #20 clock = ~clock;

  bipm_top #(.FW_NUMBER(FW)) bipm_top_i (.clock(clock), .rstn(rstn), .ce(ce), .chan_in(chan_in),
    .addr_sw(addr_sw), .hw_fault(hw_fault), .battery_low(battery_low), .term_present(term_present),
    .term_req(t_req), .term_we(t_we), .term_row(t_row), .term_col(t_col), .term_wdata(t_wdata),
    .gw_req(g_req), .gw_we(g_we), .gw_row(g_row), .gw_col(g_col), .gw_wdata(g_wdata),
    .rsp_ack(rsp_ack), .rsp_data(rsp_data), .rsp_refused(rsp_refused), .rsp_from_term(rsp_from_term),
    .relay_energised(relay_energised), .alarm_led(alarm_led));
  bipm_host_model term_host (.clock(clock), .req(t_req), .we(t_we), .row(t_row), .col(t_col), .wdata(t_wdata));
  bipm_host_model gw_host (.clock(clock), .req(g_req), .we(g_we), .row(g_row), .col(g_col), .wdata(g_wdata));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic st(input logic [1:0] m, input logic x);
    return (m == 2'h0) ? x : (m == 2'h1) ? ~x : m[0];
  endfunction

  // Gateway requests under the terminal get no note: no ack expected
  task automatic acc(input logic t, input logic w, input logic [3:0] r, input logic [3:0] c,
                     input logic [15:0] d, input logic [15:0] ed, input logic er);
    bipm_exp_s e;
    e.data = ed;
    e.refused = er;
    e.term = t;
    if (t || term_present !== 1'b1) expq.push_back(e);
    if (t) term_host.access(w, r, c, d);
    else gw_host.access(w, r, c, d);
  endtask

  task automatic rd(input logic t, input logic [3:0] r, input logic [3:0] c, input logic [15:0] ed);
    acc(t, 1'b0, r, c, 16'h0, ed, 1'b0);
  endtask

  task automatic wr(input logic [3:0] r, input logic [3:0] c, input logic [15:0] d, input logic er);
    acc(1'b0, 1'b1, r, c, d, 16'h0, er);
  endtask

  // Both ports drop on one edge, so a held terminal request is taken once
  task automatic settle();
    fork
      gw_host.idle();
      term_host.idle();
    join
    repeat (2) @(posedge clock);
  endtask

  task automatic lamp(input logic fault);
    @(negedge clock);
    `CHK("relay_energised", ~fault, relay_energised)
    `CHK("alarm_led", fault, alarm_led)
    @(posedge clock);
  endtask

  task automatic finish_test();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(negedge clock) begin
    bipm_exp_s e;
    if (rsp_ack === 1'b1) begin
      if (expq.size() == 0) begin
        n_mismatch++;
        $display("BAD rsp_ack exp 0 got 1");
      end else begin
        e = expq.pop_front();
        `CHK("rsp_data", e.data, rsp_data)
        `CHK("rsp_refused", e.refused, rsp_refused)
        `CHK("rsp_from_term", e.term, rsp_from_term)
      end
    end
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    $display("BAD watchdog exp done got timeout");
    finish_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] lf;
    logic [7:0]  pk;
    clock = 1'b0; rstn = 1'b0; ce = 1'b1; chan_in = 16'h0; addr_sw = 6'h0a;
    hw_fault = 6'h0; battery_low = 1'b0; term_present = 1'b0;
    lf = 16'h005f;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    rd(0, 4'h1, 4'h0, 16'h0000);
    rd(0, 4'h8, 4'h9, 16'h029e);
    rd(0, 4'h9, 4'h0, 16'h0000);
    rd(0, 4'h9, 4'h1, 16'h0000);
    rd(0, 4'h9, 4'h3, FW);
    rd(0, 4'h9, 4'h4, 16'h000a);
    rd(0, 4'ha, 4'h1, 16'h0000);
    acc(0, 1'b0, 4'h9, 4'h5, 16'h0, 16'h0, 1'b1);
    acc(0, 1'b0, 4'h4, 4'h0, 16'h0, 16'h0, 1'b1);
    wr(4'h0, 4'h0, 16'h0001, 1'b1);
    wr(4'h9, 4'h4, 16'h0001, 1'b1);
    for (int i = 0; i < 16; i++) wr((i < 8) ? 4'h1 : 4'h3, 4'(i % 8), 16'(i % 4), 1'b0);
    for (int i = 0; i < 16; i++) rd(0, (i < 8) ? 4'h1 : 4'h3, 4'(i % 8), 16'(i % 4));
    for (int k = 0; k < 3; k++) begin
      lf = lfsr(lf);
      chan_in <= lf;
      settle();
      for (int i = 0; i < 16; i++) rd(0, (i < 8) ? 4'h0 : 4'h2, 4'(i % 8), {15'h0, st(2'(i % 4), lf[i])});
      for (int i = 0; i < 8; i++) pk[7 - i] = st(2'(i % 4), lf[i]);
      rd(0, 4'h0, 4'h8, {8'h0, pk});
      for (int i = 0; i < 8; i++) pk[7 - i] = st(2'(i % 4), lf[i + 8]);
      rd(0, 4'h0, 4'h9, {8'h0, pk});
    end
    wr(4'h8, 4'h9, 16'h029d, 1'b0);
    wr(4'h1, 4'h0, 16'h0003, 1'b1);
    wr(4'ha, 4'h1, 16'h1111, 1'b1);
    rd(0, 4'h8, 4'h9, 16'h029d);
    wr(4'h8, 4'h9, 16'h02a8, 1'b0);
    wr(4'h3, 4'h0, 16'h0001, 1'b1);
    wr(4'h8, 4'h9, 16'h02a7, 1'b0);
    wr(4'h1, 4'h0, 16'h0003, 1'b0);
    rd(0, 4'h1, 4'h0, 16'h0003);
    wr(4'h9, 4'h5, 16'h0258, 1'b0);
    rd(0, 4'h1, 4'h0, 16'h0003);
    wr(4'h9, 4'h5, 16'h029f, 1'b0);
    for (int i = 0; i < 16; i++) rd(0, (i < 8) ? 4'h1 : 4'h3, 4'(i % 8), 16'h0000);
    // Label words come back in write order
    for (int i = 0; i < 4; i++) wr(4'ha, 4'h1, 16'ha5a0 + 16'(i), 1'b0);
    for (int i = 0; i < 4; i++) rd(0, 4'ha, 4'h1, 16'ha5a0 + 16'(i));
    settle();
    lamp(1'b0);
    // Low clock enable must hold the alarm outputs through a new fault
    ce <= 1'b0;
    hw_fault <= 6'h01;
    repeat (3) @(posedge clock);
    lamp(1'b0);
    ce <= 1'b1;
    // Each fault code and its history
    for (int i = 0; i < 6; i++) begin
      hw_fault <= 6'(1 << i);
      settle();
      lamp(1'b1);
      rd(0, 4'h9, 4'h0, 16'(101 + i));
      rd(0, 4'h9, 4'h1, (i == 0) ? 16'h0 : 16'(100 + i));
    end
    hw_fault <= 6'h0;
    battery_low <= 1'b1;
    settle();
    rd(0, 4'h9, 4'h0, 16'h006b);
    rd(0, 4'h9, 4'h1, 16'h006a);
    battery_low <= 1'b0;
    settle();
    lamp(1'b0);
    term_present <= 1'b1;
    addr_sw <= 6'h35;
    settle();
    rd(0, 4'h0, 4'h8, 16'h0);
    rd(1, 4'h9, 4'h4, 16'h0035);
    settle();
    `CHK("queue_empty", 0, expq.size())
    finish_test();
  end
endmodule
